// *** verilog/adc_conversion_sequencer.sv ***
// conversion sequencer: registers, start logic, timing, result locking
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer
    import adc_seq_pkg::*;
(
    input  wire logic             core_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic [2:0]       reg_addr_i,
    input  wire logic [7:0]       reg_wdata_i,
    input  wire logic             reg_write_i,
    input  wire logic             reg_read_i,
    output logic [7:0]            reg_rdata_o,
    input  wire logic [NTRIG-1:0] trigger_i,
    input  wire logic [RES_W-1:0] sar_result_i,
    output logic                  sample_hold_o,
    output logic                  conv_done_o,
    output logic [REF_W-1:0]      reference_select_o,
    output logic [CH_W-1:0]       channel_select_o,
    output logic                  converter_on_o,
    output logic                  conversion_done_flag_o
);
    // software registers
    logic             converter_enable;
    logic             start_conversion_bit;
    logic             auto_trigger_enable;
    logic             conversion_done_flag;
    logic [PS_W-1:0]  prescale_select;
    logic [TS_W-1:0]  trigger_source_select;
    logic [7:0]       input_select_register;
    logic             converter_power_reduction;
    logic [7:0]       result_low_byte;
    logic [7:0]       result_high_byte;

    // sequencer state
    seq_state_t       state;
    logic [5:0]       half_count;
    logic [5:0]       conv_len;
    logic [5:0]       sh_point;
    logic             first_pending;
    logic             result_locked;
    logic             trig_armed;
    logic             sel_locked;

    logic             half_tick;
    logic             rise_tick;
    logic             trig_rise;
    logic             free_run;
    logic             sw_start;
    logic             auto_start;
    logic             finish;
    logic             done_set;
    logic             powered;
    logic [RES_W-1:0] latched_result;
    logic [7:0]       next_low;
    logic [7:0]       next_high;

    assign powered  = converter_enable & ~converter_power_reduction;
    assign free_run = auto_trigger_enable & (trigger_source_select == TS_FREE_RUN);
    // start counts only with the enable bit in the same write, so enable and start may go together
    assign sw_start = reg_write_i & (reg_addr_i == ADDR_CONTROL_A) & reg_wdata_i[CA_START]
                      & reg_wdata_i[CA_ENABLE] & ~converter_power_reduction;
    // edge only counts when idle and the trigger was re-armed since the last use
    assign auto_start = auto_trigger_enable & ~free_run & trig_rise & trig_armed
                        & (state == IDLE) & powered;
    assign finish     = (state == CONVERT) & half_tick & (half_count == conv_len - 6'h01);
    assign done_set   = finish;

    adc_prescaler u_prescaler (
        .core_clk_i        (core_clk_i),
        .sys_rst_i         (sys_rst_i),
        .run_i             (powered),
        .restart_i         (auto_start),
        .prescale_select_i (prescale_select),
        .half_tick_o       (half_tick),
        .rise_tick_o       (rise_tick)
    );

    trigger_edge u_trigger (
        .core_clk_i              (core_clk_i),
        .sys_rst_i               (sys_rst_i),
        .trigger_i               (trigger_i),
        .trigger_source_select_i (trigger_source_select),
        .rise_o                  (trig_rise)
    );

    // control a: enable, auto, prescale, done flag (write one clears; set wins)
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            converter_enable     <= 1'b0;
            auto_trigger_enable  <= 1'b0;
            prescale_select      <= '0;
            conversion_done_flag <= 1'b0;
        end else begin
            if (reg_write_i && reg_addr_i == ADDR_CONTROL_A) begin
                converter_enable    <= reg_wdata_i[CA_ENABLE] & ~converter_power_reduction;
                auto_trigger_enable <= reg_wdata_i[CA_AUTO];
                prescale_select     <= reg_wdata_i[CA_PS_LSB +: PS_W];
            end
            if (done_set)
                conversion_done_flag <= 1'b1;
            else if (reg_write_i && reg_addr_i == ADDR_CONTROL_A && reg_wdata_i[CA_DONE])
                conversion_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            trigger_source_select     <= '0;
            input_select_register     <= REG_ZERO;
            converter_power_reduction <= 1'b1;
        end else if (reg_write_i) begin
            if (reg_addr_i == ADDR_CONTROL_B)
                trigger_source_select <= reg_wdata_i[TS_W-1:0];
            if (reg_addr_i == ADDR_INPUT_SELECT)
                input_select_register <= reg_wdata_i;
            if (reg_addr_i == ADDR_POWER)
                converter_power_reduction <= reg_wdata_i[PWR_BIT];
        end
    end

    // trigger re-arm: re-armed once back in idle; the source must go low and rise again
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            trig_armed <= 1'b1;
        end else if (auto_start) begin
            trig_armed <= 1'b0;
        end else if (state == IDLE && !trig_rise) begin
            trig_armed <= 1'b1;
        end
    end

    // start bit: set by software or trigger, held during any conversion, cleared at finish unless free running
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            start_conversion_bit <= 1'b0;
        end else if (sw_start || auto_start) begin
            start_conversion_bit <= 1'b1;
        end else if (!powered) begin
            start_conversion_bit <= 1'b0;
        end else if (finish && !free_run) begin
            start_conversion_bit <= 1'b0;
        end
    end

    // sequencer: half-cycle count gives the .5 sample points
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state         <= IDLE;
            half_count    <= 6'h00;
            conv_len      <= NORMAL_LEN_HALF;
            sh_point      <= NORMAL_SH;
            first_pending <= 1'b1;
            sample_hold_o <= 1'b0;
            conv_done_o   <= 1'b0;
        end else if (!powered) begin
            state         <= IDLE;
            half_count    <= 6'h00;
            first_pending <= 1'b1;
            sample_hold_o <= 1'b0;
            conv_done_o   <= 1'b0;
        end else begin
            sample_hold_o <= 1'b0;
            conv_done_o   <= finish;
            case (state)
                IDLE: begin
                    if (auto_start) begin
                        state      <= CONVERT;
                        half_count <= 6'h00;
                        conv_len   <= first_pending ? FIRST_LEN_HALF : AUTO_LEN_HALF;
                        sh_point   <= first_pending ? FIRST_SH : AUTO_SH;
                    end else if (sw_start || start_conversion_bit) begin
                        state <= WAIT_EDGE;
                    end
                end
                WAIT_EDGE: begin
                    if (rise_tick) begin
                        state      <= CONVERT;
                        half_count <= 6'h00;
                        conv_len   <= first_pending ? FIRST_LEN_HALF : NORMAL_LEN_HALF;
                        sh_point   <= first_pending ? FIRST_SH : NORMAL_SH;
                    end
                end
                CONVERT: begin
                    if (half_tick) begin
                        half_count <= 6'(half_count + 6'h01);
                        if (half_count == sh_point - 6'h01)
                            sample_hold_o <= 1'b1;
                    end
                    if (finish) begin
                        first_pending <= 1'b0;
                        half_count    <= 6'h00;
                        conv_len      <= NORMAL_LEN_HALF;
                        sh_point      <= NORMAL_SH;
                        // free running restarts at once; otherwise back to idle
                        state <= free_run ? CONVERT : IDLE;
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end

    // selection lock: open until start, closed during, reopens in last cycle
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sel_locked <= 1'b0;
        end else if (state == CONVERT && half_tick && half_count == conv_len - LAST_CYCLE_HALF - 6'h01) begin
            sel_locked <= 1'b0;
        end else if (state != CONVERT && (auto_start || (state == WAIT_EDGE && rise_tick))) begin
            sel_locked <= 1'b1;
        end else if (finish && free_run) begin
            sel_locked <= 1'b1;
        end else if (!powered) begin
            sel_locked <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reference_select_o <= '0;
            channel_select_o   <= '0;
            converter_on_o     <= 1'b0;
        end else begin
            converter_on_o <= powered;
            // selection reaches the analog side only while enabled
            if (powered && !sel_locked) begin
                reference_select_o <= input_select_register[IS_REF_LSB +: REF_W];
                channel_select_o   <= input_select_register[IS_CH_LSB +: CH_W];
            end
        end
    end

    // result alignment
    assign latched_result = sar_result_i;
    always_comb begin
        if (input_select_register[IS_ALIGN]) begin
            next_high = latched_result[RES_W-1:RES_W-8];
            next_low  = {latched_result[1:0], 6'h00};
        end else begin
            next_high = {6'h00, latched_result[RES_W-1:8]};
            next_low  = latched_result[7:0];
        end
    end

    // result lock: low-byte read blocks updates until high-byte read
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            result_locked <= 1'b0;
        end else if (reg_read_i && reg_addr_i == ADDR_RESULT_HIGH) begin
            result_locked <= 1'b0;
        end else if (reg_read_i && reg_addr_i == ADDR_RESULT_LOW) begin
            result_locked <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            result_low_byte  <= REG_ZERO;
            result_high_byte <= REG_ZERO;
        end else if (finish && !result_locked) begin
            // a blocked result is dropped but the flag is still raised
            result_low_byte  <= next_low;
            result_high_byte <= next_high;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            conversion_done_flag_o <= 1'b0;
        end else begin
            conversion_done_flag_o <= conversion_done_flag | done_set;
        end
    end

    // read port: data in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= REG_ZERO;
        end else if (reg_read_i) begin
            case (reg_addr_i)
                ADDR_RESULT_LOW:   reg_rdata_o <= result_low_byte;
                ADDR_RESULT_HIGH:  reg_rdata_o <= result_high_byte;
                ADDR_CONTROL_A:    reg_rdata_o <= {converter_enable,
                                                   start_conversion_bit | (state != IDLE),
                                                   auto_trigger_enable, conversion_done_flag,
                                                   1'b0, prescale_select};
                ADDR_CONTROL_B:    reg_rdata_o <= {5'h00, trigger_source_select};
                ADDR_INPUT_SELECT: reg_rdata_o <= input_select_register;
                ADDR_POWER:        reg_rdata_o <= {7'h00, converter_power_reduction};
                default:           reg_rdata_o <= REG_ZERO;
            endcase
        end else begin
            reg_rdata_o <= REG_ZERO;
        end
    end
endmodule // adc_conversion_sequencer
`default_nettype wire

// *** verilog/adc_seq_pkg.sv ***
// constants shared by the conversion sequencer design
package adc_seq_pkg;
    // register word addresses (byte-wide registers on the plain port)
    localparam logic [2:0] ADDR_RESULT_LOW   = 3'h0;
    localparam logic [2:0] ADDR_RESULT_HIGH  = 3'h1;
    localparam logic [2:0] ADDR_CONTROL_A    = 3'h2;
    localparam logic [2:0] ADDR_CONTROL_B    = 3'h3;
    localparam logic [2:0] ADDR_INPUT_SELECT = 3'h4;
    localparam logic [2:0] ADDR_POWER        = 3'h5;

    // control a fields
    localparam int CA_ENABLE  = 7;
    localparam int CA_START   = 6;
    localparam int CA_AUTO    = 5;
    localparam int CA_DONE    = 4;
    localparam int CA_PS_LSB  = 0;
    localparam int PS_W       = 3;
    // control b field
    localparam int TS_W       = 3;
    // input select fields
    localparam int IS_REF_LSB = 6;
    localparam int IS_ALIGN   = 5;
    localparam int IS_CH_LSB  = 0;
    localparam int REF_W      = 2;
    localparam int CH_W       = 4;
    localparam int PWR_BIT    = 0;

    localparam int RES_W      = 10;
    localparam int NTRIG      = 8;
    // trigger select code that means "completion flag" (free running)
    localparam logic [TS_W-1:0] TS_FREE_RUN = 3'h0;

    // converter clock cycle counts (NORMAL_CYCLES and FIRST_CYCLES in whole cycles, the rest in half cycles, since sampling lands on halves)
    localparam int NORMAL_CYCLES    = 13;
    localparam int FIRST_CYCLES     = 25;
    localparam int AUTO_HALF_CYCLES = 27;
    localparam int NORMAL_SH_HALF   = 3;
    localparam int FIRST_SH_HALF    = 27;
    localparam int AUTO_SH_HALF     = 4;
    localparam logic [5:0] NORMAL_LEN_HALF = 6'(2 * NORMAL_CYCLES);
    localparam logic [5:0] FIRST_LEN_HALF  = 6'(2 * FIRST_CYCLES);
    localparam logic [5:0] AUTO_LEN_HALF   = 6'(AUTO_HALF_CYCLES);
    localparam logic [5:0] NORMAL_SH       = 6'(NORMAL_SH_HALF);
    localparam logic [5:0] FIRST_SH        = 6'(FIRST_SH_HALF);
    localparam logic [5:0] AUTO_SH         = 6'(AUTO_SH_HALF);
    localparam logic [5:0] LAST_CYCLE_HALF = 6'h02;

    localparam logic [7:0] REG_ZERO = 8'h00;

    typedef enum logic [1:0] {
        IDLE,
        WAIT_EDGE,
        CONVERT
    } seq_state_t;
endpackage : adc_seq_pkg

// *** verilog/adc_prescaler.sv ***
// converter clock prescaler: half-period enable pulses
`timescale 1ns/1ps
`default_nettype none
module adc_prescaler
    import adc_seq_pkg::*;
(
    input  wire logic            core_clk_i,
    input  wire logic            sys_rst_i,
    input  wire logic            run_i,
    input  wire logic            restart_i,
    input  wire logic [PS_W-1:0] prescale_select_i,
    output logic                 half_tick_o,
    output logic                 rise_tick_o
);
    logic [7:0] count;
    logic       phase;
    logic [7:0] half_len;

    // division 2^sel with sel 0 treated as 2; half period = division / 2
    always_comb begin
        half_len = (prescale_select_i == 3'h0) ? 8'h01 : 8'(8'h01 << (prescale_select_i - 3'h1));
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count       <= 8'h00;
            phase       <= 1'b0;
            half_tick_o <= 1'b0;
            rise_tick_o <= 1'b0;
        end else if (!run_i || restart_i) begin
            // held in reset while disabled, and restarted by a trigger
            count       <= 8'h00;
            phase       <= 1'b0;
            half_tick_o <= 1'b0;
            rise_tick_o <= 1'b0;
        end else if (count == half_len - 8'h01) begin
            count       <= 8'h00;
            phase       <= ~phase;
            half_tick_o <= 1'b1;
            rise_tick_o <= phase;
        end else begin
            count       <= 8'(count + 8'h01);
            half_tick_o <= 1'b0;
            rise_tick_o <= 1'b0;
        end
    end
endmodule // adc_prescaler
`default_nettype wire

// *** verilog/trigger_edge.sv ***
// trigger input synchroniser and rising edge detector
`timescale 1ns/1ps
`default_nettype none
module trigger_edge
    import adc_seq_pkg::*;
(
    input  wire logic             core_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic [NTRIG-1:0] trigger_i,
    input  wire logic [TS_W-1:0]  trigger_source_select_i,
    output logic                  rise_o
);
    logic [NTRIG-1:0] sync1;
    logic [NTRIG-1:0] sync2;
    logic [NTRIG-1:0] sync3;
    logic             prev;
    logic             cur;

    // a level counts once the second and third stages agree
    genvar i;
    for (i = 0; i < NTRIG; i++) begin : g_sync
        always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                sync1[i] <= 1'b0;
                sync2[i] <= 1'b0;
                sync3[i] <= 1'b0;
            end else begin
                sync1[i] <= trigger_i[i];
                sync2[i] <= sync1[i];
                sync3[i] <= sync2[i];
            end
        end
    end

    always_comb begin
        cur = (sync2[trigger_source_select_i] == sync3[trigger_source_select_i])
              ? sync3[trigger_source_select_i] : prev;
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prev   <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            prev   <= cur;
            rise_o <= cur & ~prev;
        end
    end
endmodule // trigger_edge
`default_nettype wire

// *** verification/adc_seq_checker.sv ***
// port-level assertions for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_seq_checker
    import adc_seq_pkg::*;
(
    input wire logic             core_clk_i,
    input wire logic             sys_rst_i,
    input wire logic [2:0]       reg_addr_i,
    input wire logic [7:0]       reg_wdata_i,
    input wire logic             reg_write_i,
    input wire logic             reg_read_i,
    input wire logic [7:0]       reg_rdata_o,
    input wire logic [NTRIG-1:0] trigger_i,
    input wire logic [RES_W-1:0] sar_result_i,
    input wire logic             sample_hold_o,
    input wire logic             conv_done_o,
    input wire logic [REF_W-1:0] reference_select_o,
    input wire logic [CH_W-1:0]  channel_select_o,
    input wire logic             converter_on_o,
    input wire logic             conversion_done_flag_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_sh_needs_on: assert property (sample_hold_o |-> converter_on_o)
        else $error("sample point while converter off");
    a_sh_once_per: assert property (sample_hold_o |=> !sample_hold_o until conv_done_o)
        else $error("second sample point before completion");
    // bound holds for prescale codes up to division 64 (the tests use division 4 only)
    a_sh_then_done: assert property (sample_hold_o |-> ##[1:1000] conv_done_o)
        else $error("no completion after sample point");
    a_done_sets_flag: assert property (conv_done_o |-> ##[0:1] conversion_done_flag_o)
        else $error("completion without done flag");
    a_done_one_cycle: assert property (conv_done_o |=> !conv_done_o)
        else $error("completion pulse too long");
    a_sel_locked: assert property (sample_hold_o |=> $stable({reference_select_o, channel_select_o})[*8])
        else $error("selection moved during conversion");
    a_sel_needs_on: assert property ($changed({reference_select_o, channel_select_o})
        |-> ##[0:1] (converter_on_o || $past(converter_on_o)))
        else $error("selection applied while disabled");
    a_disable_off: assert property (reg_write_i && reg_addr_i == ADDR_CONTROL_A && !reg_wdata_i[CA_ENABLE]
        |-> ##2 !converter_on_o)
        else $error("converter still on after disable");
endmodule // adc_seq_checker
bind adc_conversion_sequencer adc_seq_checker u_adc_seq_checker (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .trigger_i(trigger_i),
    .sar_result_i(sar_result_i), .sample_hold_o(sample_hold_o), .conv_done_o(conv_done_o),
    .reference_select_o(reference_select_o), .channel_select_o(channel_select_o),
    .converter_on_o(converter_on_o), .conversion_done_flag_o(conversion_done_flag_o));
`default_nettype wire

// *** verification/tb_adc_conversion_sequencer.sv ***
// register-level testbench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_sequencer
    import adc_seq_pkg::*;
;
    localparam int LIM = 150;
    logic             core_clk_i   = 1'b0;
    logic             sys_rst_i    = 1'b1;
    logic [2:0]       reg_addr_i   = 3'h0;
    logic [7:0]       reg_wdata_i  = 8'h00;
    logic             reg_write_i  = 1'b0;
    logic             reg_read_i   = 1'b0;
    logic [NTRIG-1:0] trigger_i    = 8'h00;
    logic [RES_W-1:0] sar_result_i = 10'h000;
    logic [7:0]       reg_rdata_o;
    logic             sample_hold_o, conv_done_o, converter_on_o, conversion_done_flag_o;
    logic [REF_W-1:0] reference_select_o;
    logic [CH_W-1:0]  channel_select_o;
    int               n, n_mismatch, checked, n_sh;

    always @(posedge core_clk_i) begin
        if (sample_hold_o === 1'b1)
            n_sh++;
    end

    adc_conversion_sequencer u_adc_conversion_sequencer (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .trigger_i(trigger_i),
        .sar_result_i(sar_result_i), .sample_hold_o(sample_hold_o), .conv_done_o(conv_done_o),
        .reference_select_o(reference_select_o), .channel_select_o(channel_select_o),
        .converter_on_o(converter_on_o), .conversion_done_flag_o(conversion_done_flag_o));

    always #25 core_clk_i = ~core_clk_i;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // trailing idle edge keeps two back-to-back calls from driving a strobe twice in one step
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        reg_addr_i  <= a;
        reg_wdata_i <= v;
        reg_write_i <= 1'b1;
        @(posedge core_clk_i);
        reg_write_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic rc(input logic [2:0] a, input logic [7:0] exp);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge core_clk_i);
        reg_read_i <= 1'b0;
        @(posedge core_clk_i);
        chk(reg_rdata_o, exp);
    endtask
    task automatic wait_done(input int lim);
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (conv_done_o !== 1'b1 && n < lim);
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 50);
        n_mismatch++;
        results();
    end

    initial begin
        n_mismatch = 0;
        checked = 0;
        repeat (8) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge core_clk_i);
        rc(ADDR_POWER, 8'h01);
        rc(3'h6, 8'h00);
        wr(ADDR_INPUT_SELECT, 8'h43);
        wr(ADDR_CONTROL_A, 8'hC2);
        wait_done(LIM);
        chk({7'h0, converter_on_o}, 8'h00);
        chk(8'(n), 8'(LIM));
        chk({reference_select_o, 2'b00, channel_select_o}, 8'h00);
        wr(ADDR_POWER, 8'h00);
        sar_result_i <= 10'h2A5;
        wr(ADDR_CONTROL_A, 8'hC2);
        rc(ADDR_CONTROL_A, 8'hC2);
        chk({reference_select_o, 2'b00, channel_select_o}, 8'h43);
        wait_done(400);
        chk(8'(n >= 92 && n <= 110), 8'h01);
        chk({7'h0, conversion_done_flag_o}, 8'h01);
        rc(ADDR_CONTROL_A, 8'h92);
        rc(ADDR_RESULT_LOW, 8'hA5);
        rc(ADDR_RESULT_HIGH, 8'h02);
        sar_result_i <= 10'h1C3;
        wr(ADDR_INPUT_SELECT, 8'h63);
        n_sh = 0;
        wr(ADDR_CONTROL_A, 8'hD2);
        // let the conversion take hold before moving the channel
        repeat (8) @(posedge core_clk_i);
        wr(ADDR_INPUT_SELECT, 8'h65);
        chk({4'h0, channel_select_o}, 8'h03);
        wait_done(400);
        chk(8'(n >= 36 && n <= 62), 8'h01);
        chk(8'(n_sh), 8'h01);
        chk({4'h0, channel_select_o}, 8'h05);
        rc(ADDR_RESULT_LOW, 8'hC0);
        sar_result_i <= 10'h0F0;
        wr(ADDR_CONTROL_A, 8'hD2);
        wait_done(LIM);
        rc(ADDR_CONTROL_A, 8'h92);
        rc(ADDR_RESULT_HIGH, 8'h70);
        wr(ADDR_CONTROL_A, 8'hD2);
        wait_done(LIM);
        rc(ADDR_RESULT_HIGH, 8'h3C);
        wr(ADDR_CONTROL_B, 8'h02);
        wr(ADDR_CONTROL_A, 8'hB2);
        trigger_i <= 8'h08;
        wait_done(LIM);
        chk(8'(n), 8'(LIM));
        trigger_i <= 8'h04;
        repeat (20) @(posedge core_clk_i);
        rc(ADDR_CONTROL_A, 8'hE2);
        trigger_i <= 8'h00;
        repeat (4) @(posedge core_clk_i);
        trigger_i <= 8'h04;
        wait_done(LIM);
        chk(8'(n < LIM), 8'h01);
        wait_done(LIM);
        chk(8'(n), 8'(LIM));
        trigger_i <= 8'h00;
        repeat (4) @(posedge core_clk_i);
        trigger_i <= 8'h04;
        wait_done(LIM);
        chk(8'(n >= 50 && n <= 70), 8'h01);
        wr(ADDR_CONTROL_A, 8'hF2);
        wait_done(LIM);
        chk(8'(n < LIM), 8'h01);
        wr(ADDR_CONTROL_B, {5'h00, TS_FREE_RUN});
        wr(ADDR_CONTROL_A, 8'hF2);
        for (int i = 0; i < 3; i++) begin
            wait_done(LIM);
            chk(8'(n < LIM), 8'h01);
        end
        rc(ADDR_CONTROL_A, 8'hF2);
        wait_done(LIM);
        wr(ADDR_CONTROL_A, 8'h00);
        // the registered output drops one edge after the enable register clears
        @(posedge core_clk_i);
        chk({7'h0, converter_on_o}, 8'h00);
        wait_done(LIM);
        chk(8'(n), 8'(LIM));
        results();
    end
endmodule // tb_adc_conversion_sequencer
`default_nettype wire
